//--- rtl/sps_page_select.sv
// SRAM page selection, paging registers, flag register and stack pointer wrap
//
// Operation
// - Reset gives page mode 00b; indexed accesses then go to page 0.
// - Mode 01b sends indexed accesses to stack page; normal stay on page 0.
// - Mode 10b sends indexed accesses to index page; index page unused otherwise.
// - Mode 11b sends indexed accesses to stack page.
// - Normal accesses use current page only in modes 10b and 11b.
// - Current page never affects indexed or stack accesses.
// - Move pointer byte read and written back on the same page as normal accesses.
// - Move read data uses move-read page bits [2:0].
// - Move write data uses move-write page bits [2:0].
// - Move read and write page selection ignores page mode.
// - Stack uses stack page always; resets 00h; new value applies immediately.
// - Interrupt entry pushes flags then clears them, forcing mode 00b.
// - Return restores pushed flags; handler restores its own page pointers.
// - Indexed register-space accesses are not paged.
// - Four 8-bit scratch registers, reachable in every bank, page independent.
// - Each pointer selects one of eight 256-byte pages.
// - Stack pointer wraps 00h and FFh within one page.
`include "sps_defines.svh"
`default_nettype none
module sps_page_select (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,

  // Data access from the core
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [2:0] mem_kind_i,
  input wire logic [7:0] mem_offset_i,
  input wire logic mem_reg_space_i,
  output logic sram_req_o,
  output logic sram_we_o,
  output logic [10:0] sram_addr_o,
  output logic reg_req_o,
  output logic [7:0] reg_addr_o,

  // Register space access
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_bank_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,

  // Flag register handling
  input wire logic flag_wr_i,
  input wire logic [7:0] flag_wdata_i,
  input wire logic irq_entry_i,
  input wire logic irq_return_i,
  input wire logic [7:0] flag_popped_i,
  output logic [7:0] flag_o,
  output logic [7:0] flag_pushed_o,

  // Stack pointer
  input wire logic sp_wr_i,
  input wire logic [7:0] sp_wdata_i,
  input wire logic sp_push_i,
  input wire logic sp_pop_i,
  output logic [7:0] stack_pointer_o
);
  // Architectural state
  logic [2:0] current_page_pointer;
  logic [2:0] stack_page_pointer;
  logic [2:0] index_page_pointer;
  logic [2:0] move_read_page_pointer;
  logic [2:0] move_write_page_pointer;
  logic [7:0] scratch_data_registers [`SPS_SCRATCH_COUNT];
  logic [7:0] flag_q;
  logic [7:0] flag_pushed_q;
  logic [7:0] stack_pointer;

  // Next values, one per state group
  logic [2:0] next_current_page_pointer;
  logic [2:0] next_stack_page_pointer;
  logic [2:0] next_index_page_pointer;
  logic [2:0] next_move_read_page_pointer;
  logic [2:0] next_move_write_page_pointer;
  logic [7:0] next_scratch [`SPS_SCRATCH_COUNT];
  logic [7:0] next_flag;
  logic [7:0] next_flag_pushed;
  logic [7:0] next_stack_pointer;

  // Selection and decode
  logic normal_paged;
  logic [2:0] indexed_page;
  logic [7:0] rd_mux;
  logic rd_hit;
  logic [2:0] sel_page;
  logic [7:0] next_rdata;
  logic next_hit;
  logic next_sram_req;
  logic next_sram_we;
  logic [10:0] next_sram_addr;
  logic next_reg_req;
  logic [7:0] next_reg_addr;

  // Output registers: every access and readback port is driven straight from one of these
  logic [7:0] rdata_q;
  logic hit_q;
  logic sram_req_q;
  logic sram_we_q;
  logic [10:0] sram_addr_q;
  logic reg_req_q;
  logic [7:0] reg_addr_q;

  // Page mode is the top two flag bits
  sps_pkg::sps_mode_t page_mode_field;

  assign page_mode_field = sps_pkg::sps_mode_t'(flag_q[`SPS_MODE_MSB:`SPS_MODE_LSB]);

  // Paging registers sit in bank 0 only; reserved bits are dropped and read as zero
  always_comb begin
    next_current_page_pointer = current_page_pointer;
    next_stack_page_pointer = stack_page_pointer;
    next_index_page_pointer = index_page_pointer;
    next_move_read_page_pointer = move_read_page_pointer;
    next_move_write_page_pointer = move_write_page_pointer;
    if (reg_wr_i && !reg_bank_i) begin
      case (reg_addr_i)
        `SPS_OFF_CUR_PAGE: next_current_page_pointer = reg_wdata_i[`SPS_PAGE_MSB:0];
        `SPS_OFF_STK_PAGE: next_stack_page_pointer = reg_wdata_i[`SPS_PAGE_MSB:0];
        `SPS_OFF_IDX_PAGE: next_index_page_pointer = reg_wdata_i[`SPS_PAGE_MSB:0];
        `SPS_OFF_MVR_PAGE: next_move_read_page_pointer = reg_wdata_i[`SPS_PAGE_MSB:0];
        `SPS_OFF_MVW_PAGE: next_move_write_page_pointer = reg_wdata_i[`SPS_PAGE_MSB:0];
        default: next_current_page_pointer = current_page_pointer;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      current_page_pointer <= `SPS_PAGE_RST;
      stack_page_pointer <= `SPS_PAGE_RST;
      index_page_pointer <= `SPS_PAGE_RST;
      move_read_page_pointer <= `SPS_PAGE_RST;
      move_write_page_pointer <= `SPS_PAGE_RST;
    end else if (clk_en_i) begin
      current_page_pointer <= next_current_page_pointer;
      stack_page_pointer <= next_stack_page_pointer;
      index_page_pointer <= next_index_page_pointer;
      move_read_page_pointer <= next_move_read_page_pointer;
      move_write_page_pointer <= next_move_write_page_pointer;
    end
  end

  // Scratch registers decode on the low address byte in either bank
  // so a handler can use them without switching banks or pages
  generate
    for (genvar g = 0; g < `SPS_SCRATCH_COUNT; g++) begin : g_scratch
      always_comb begin
        next_scratch[g] = scratch_data_registers[g];
        if (reg_wr_i && reg_addr_i == (`SPS_OFF_SCRATCH_BASE + 8'(g))) begin
          next_scratch[g] = reg_wdata_i;
        end
      end
      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          scratch_data_registers[g] <= `SPS_SCRATCH_RST;
        end else if (clk_en_i) begin
          scratch_data_registers[g] <= next_scratch[g];
        end
      end
    end
  endgenerate

  // Flags: interrupt entry wins over a same-cycle software write
  // Return restores the whole byte, page mode included, whatever the handler set
  always_comb begin
    next_flag = flag_q;
    if (irq_entry_i) begin
      next_flag = `SPS_FLAG_RST;
    end else if (irq_return_i) begin
      next_flag = flag_popped_i;
    end else if (flag_wr_i) begin
      next_flag = flag_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flag_q <= `SPS_FLAG_RST;
    end else if (clk_en_i) begin
      flag_q <= next_flag;
    end
  end

  // Copy of the flags taken at entry, for the core to push onto the stack
  always_comb begin
    next_flag_pushed = flag_pushed_q;
    if (irq_entry_i) begin
      next_flag_pushed = flag_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flag_pushed_q <= `SPS_FLAG_RST;
    end else if (clk_en_i) begin
      flag_pushed_q <= next_flag_pushed;
    end
  end

  // Stack pointer wraps in 8 bits so the stack never leaves its page
  // A load beats push and pop; push and pop together cancel
  always_comb begin
    next_stack_pointer = stack_pointer;
    if (sp_wr_i) begin
      next_stack_pointer = sp_wdata_i;
    end else if (sp_push_i && !sp_pop_i) begin
      next_stack_pointer = stack_pointer + 8'h01;
    end else if (sp_pop_i && !sp_push_i) begin
      next_stack_pointer = stack_pointer - 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      stack_pointer <= `SPS_SP_RST;
    end else if (clk_en_i) begin
      stack_pointer <= next_stack_pointer;
    end
  end

  // Mode decode; the index pointer only counts in mode 10b
  always_comb begin
    normal_paged = page_mode_field[1];
    indexed_page = 3'h0;
    case (page_mode_field)
      sps_pkg::SPS_MODE_FLAT: indexed_page = 3'h0;
      sps_pkg::SPS_MODE_STACK_IDX: indexed_page = stack_page_pointer;
      sps_pkg::SPS_MODE_PAGED: indexed_page = index_page_pointer;
      sps_pkg::SPS_MODE_PAGED_STK: indexed_page = stack_page_pointer;
      default: indexed_page = 3'h0;
    endcase
  end

  // Page choice per access kind
  always_comb begin
    sel_page = 3'h0;
    case (sps_pkg::sps_acc_t'(mem_kind_i))
      sps_pkg::SPS_ACC_NORMAL: begin
        if (normal_paged) begin
          sel_page = current_page_pointer;
        end
      end
      // Pointer byte of a move stays with normal data: current page in modes 10b and 11b, page 0 otherwise
      sps_pkg::SPS_ACC_MVI_PTR: begin
        if (normal_paged) begin
          sel_page = current_page_pointer;
        end
      end
      sps_pkg::SPS_ACC_INDEXED: sel_page = indexed_page;
      sps_pkg::SPS_ACC_STACK: sel_page = stack_page_pointer;
      sps_pkg::SPS_ACC_MVI_RD: sel_page = move_read_page_pointer;
      sps_pkg::SPS_ACC_MVI_WR: sel_page = move_write_page_pointer;
      default: sel_page = 3'h0;
    endcase
  end

  // Register-space accesses bypass paging entirely
  always_comb begin
    next_sram_req = mem_req_i && !mem_reg_space_i;
    next_reg_req = mem_req_i && mem_reg_space_i;
    next_reg_addr = mem_offset_i;
    // Write qualifier is dropped without a request so a stale one never shows
    next_sram_we = mem_we_i && next_sram_req;
    next_sram_addr = {sel_page, mem_offset_i};
  end

  // Register readback
  always_comb begin
    rd_mux = 8'h00;
    rd_hit = 1'b1;
    if (reg_addr_i[7:2] == 6'(`SPS_OFF_SCRATCH_BASE >> 2)) begin
      rd_mux = scratch_data_registers[reg_addr_i[1:0]];
    end else if (reg_bank_i) begin
      rd_hit = 1'b0;
    end else begin
      case (reg_addr_i)
        `SPS_OFF_CUR_PAGE: rd_mux = {5'h00, current_page_pointer};
        `SPS_OFF_STK_PAGE: rd_mux = {5'h00, stack_page_pointer};
        `SPS_OFF_IDX_PAGE: rd_mux = {5'h00, index_page_pointer};
        `SPS_OFF_MVR_PAGE: rd_mux = {5'h00, move_read_page_pointer};
        `SPS_OFF_MVW_PAGE: rd_mux = {5'h00, move_write_page_pointer};
        default: rd_hit = 1'b0;
      endcase
    end
    next_rdata = reg_rd_i ? rd_mux : 8'h00;
    next_hit = reg_rd_i && rd_hit;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
    end else if (clk_en_i) begin
      rdata_q <= next_rdata;
      hit_q <= next_hit;
    end
  end

  // Data-path registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sram_req_q <= 1'b0;
      sram_we_q <= 1'b0;
      sram_addr_q <= 11'h000;
      reg_req_q <= 1'b0;
      reg_addr_q <= 8'h00;
    end else if (clk_en_i) begin
      sram_req_q <= next_sram_req;
      sram_we_q <= next_sram_we;
      sram_addr_q <= next_sram_addr;
      reg_req_q <= next_reg_req;
      reg_addr_q <= next_reg_addr;
    end
  end

  // Ports come straight from the registers
  assign sram_req_o = sram_req_q;
  assign sram_we_o = sram_we_q;
  assign sram_addr_o = sram_addr_q;
  assign reg_req_o = reg_req_q;
  assign reg_addr_o = reg_addr_q;
  assign reg_rdata_o = rdata_q;
  assign reg_hit_o = hit_q;
  assign flag_o = flag_q;
  assign flag_pushed_o = flag_pushed_q;
  assign stack_pointer_o = stack_pointer;
endmodule
`default_nettype wire

//--- include/sps_defines.svh
// Register offsets, field positions and reset values of the SRAM page-select block
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH
`define SPS_OFF_SCRATCH_BASE 8'h60
`define SPS_OFF_CUR_PAGE 8'hD0
`define SPS_OFF_STK_PAGE 8'hD1
`define SPS_OFF_IDX_PAGE 8'hD3
`define SPS_OFF_MVR_PAGE 8'hD4
`define SPS_OFF_MVW_PAGE 8'hD5
`define SPS_PAGE_MSB 2
`define SPS_MODE_MSB 7
`define SPS_MODE_LSB 6
`define SPS_PAGE_RST 3'h0
`define SPS_FLAG_RST 8'h00
`define SPS_SCRATCH_RST 8'h00
`define SPS_SCRATCH_COUNT 4
`define SPS_SP_RST 8'h00
`endif

//--- include/sps_pkg.sv
// Types shared by the SRAM page-select block
`default_nettype none
package sps_pkg;
  typedef enum logic [1:0] {
    SPS_MODE_FLAT = 2'h0,
    SPS_MODE_STACK_IDX = 2'h1,
    SPS_MODE_PAGED = 2'h2,
    SPS_MODE_PAGED_STK = 2'h3
  } sps_mode_t;
  typedef enum logic [2:0] {
    SPS_ACC_NORMAL = 3'h0,
    SPS_ACC_INDEXED = 3'h1,
    SPS_ACC_STACK = 3'h2,
    SPS_ACC_MVI_PTR = 3'h3,
    SPS_ACC_MVI_RD = 3'h4,
    SPS_ACC_MVI_WR = 3'h5
  } sps_acc_t;
endpackage
`default_nettype wire

//--- testbench/sps_page_select_assertions.sv
// Port-level checker for the SRAM page-select block
`default_nettype none
module sps_page_select_chk (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic mem_req_i,
  input wire logic [2:0] mem_kind_i,
  input wire logic [7:0] mem_offset_i,
  input wire logic mem_reg_space_i,
  input wire logic irq_entry_i,
  input wire logic sp_wr_i,
  input wire logic sp_push_i,
  input wire logic sp_pop_i,
  input wire logic sram_req_o,
  input wire logic [10:0] sram_addr_o,
  input wire logic reg_req_o,
  input wire logic [7:0] reg_addr_o,
  input wire logic [7:0] flag_o,
  input wire logic [7:0] flag_pushed_o,
  input wire logic [7:0] stack_pointer_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire go_sram = mem_req_i && clk_en_i && !mem_reg_space_i;
  wire go_sp = clk_en_i && !sp_wr_i;
  a_sram_offset: assert property (go_sram |=>
    sram_req_o && !reg_req_o && sram_addr_o[7:0] == $past(mem_offset_i)) else $error("offset lost");
  a_reg_unpaged: assert property (mem_req_i && clk_en_i && mem_reg_space_i |=>
    reg_req_o && !sram_req_o && reg_addr_o == $past(mem_offset_i)) else $error("reg paged");
  a_no_stray: assert property (clk_en_i && !mem_req_i |=>
    !sram_req_o && !reg_req_o) else $error("stray access");
  a_flat_page0: assert property (go_sram && flag_o[7:6] == 2'h0 && mem_kind_i <= 3'h1 |=>
    sram_addr_o[10:8] == 3'h0) else $error("flat mode off page 0");
  a_normal_page0: assert property (go_sram && !flag_o[7] && mem_kind_i == 3'h0 |=>
    sram_addr_o[10:8] == 3'h0) else $error("normal access paged");
  a_irq_clear: assert property (clk_en_i && irq_entry_i |=>
    flag_o == 8'h00 && flag_pushed_o == $past(flag_o)) else $error("entry flags wrong");
  a_sp_wrap_up: assert property (go_sp && sp_push_i && !sp_pop_i |=>
    stack_pointer_o - $past(stack_pointer_o) == 8'h01) else $error("push step wrong");
  a_sp_wrap_down: assert property (go_sp && sp_pop_i && !sp_push_i |=>
    $past(stack_pointer_o) - stack_pointer_o == 8'h01) else $error("pop step wrong");
endmodule
bind sps_page_select sps_page_select_chk u_chk (.*);
`default_nettype wire

//--- testbench/sps_core_model.sv
// Core-side model issuing data accesses into the page-select block
`default_nettype none
module sps_core_model (
  input wire logic clk_i,
  output logic req_o,
  output logic we_o,
  output logic [2:0] kind_o,
  output logic [7:0] offset_o,
  output logic reg_space_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {req_o, we_o, kind_o, offset_o, reg_space_o} = '0;
  // The released offset is inverted so a stale offset is never mistaken for a live one
  task automatic access(input logic [2:0] kind, input logic [7:0] off, input logic rs);
    @(posedge clk_i);
    req_o <= 1'b1;
    we_o <= (kind == 3'h5);
    kind_o <= kind;
    offset_o <= off;
    reg_space_o <= rs;
    @(posedge clk_i);
    req_o <= 1'b0;
    offset_o <= ~off;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_sps_page_select.sv
// Self-checking bench for the SRAM page-select block
`include "sps_defines.svh"
`default_nettype none
module tb_sps_page_select;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] CUR = 3'h1, STK = 3'h2, IDX = 3'h3, MVR = 3'h4, MVW = 3'h6;
  localparam logic [5:0] FW = 6'h20, IE = 6'h10, IR = 6'h08, SW = 6'h04, PU = 6'h02, PO = 6'h01;
  localparam logic [7:0] PG_ADDR [5] = '{`SPS_OFF_CUR_PAGE, `SPS_OFF_STK_PAGE,
    `SPS_OFF_IDX_PAGE, `SPS_OFF_MVR_PAGE, `SPS_OFF_MVW_PAGE};
  localparam logic [2:0] PG_VAL [5] = '{CUR, STK, IDX, MVR, MVW};
  logic ref_clk_i, rst_n_i, clk_en_i, reg_wr_i, reg_rd_i, reg_bank_i;
  logic flag_wr_i, irq_entry_i, irq_return_i, sp_wr_i, sp_push_i, sp_pop_i;
  logic [7:0] reg_addr_i, reg_wdata_i, flag_wdata_i, flag_popped_i, sp_wdata_i;
  logic mem_req_i, mem_we_i, mem_reg_space_i, sram_req_o, sram_we_o, reg_req_o, reg_hit_o;
  logic [2:0] mem_kind_i;
  logic [7:0] mem_offset_i, reg_addr_o, reg_rdata_o, flag_o, flag_pushed_o, stack_pointer_o;
  logic [10:0] sram_addr_o;
  int bad_count = 0;
  int n_checks = 0;
  sps_page_select dut (.*);
  sps_core_model core (.clk_i(ref_clk_i), .req_o(mem_req_i), .we_o(mem_we_i),
    .kind_o(mem_kind_i), .offset_o(mem_offset_i), .reg_space_o(mem_reg_space_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic bank, input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk_i);
    {reg_wr_i, reg_bank_i, reg_addr_i, reg_wdata_i} <= {1'b1, bank, addr, data};
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_chk(input logic [7:0] addr, input logic [11:0] exp);
    @(posedge ref_clk_i);
    {reg_rd_i, reg_bank_i, reg_addr_i} <= {2'b10, addr};
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("reg_read", {3'h0, reg_hit_o, reg_rdata_o}, exp);
  endtask
  // Flag, interrupt and stack pointer strobes share one data value
  task automatic strobe(input logic [5:0] sel, input logic [7:0] val);
    @(posedge ref_clk_i);
    {flag_wr_i, irq_entry_i, irq_return_i, sp_wr_i, sp_push_i, sp_pop_i} <= sel;
    {flag_wdata_i, flag_popped_i, sp_wdata_i} <= {val, val, val};
    @(posedge ref_clk_i);
    {flag_wr_i, irq_entry_i, irq_return_i, sp_wr_i, sp_push_i, sp_pop_i} <= 6'h00;
    #1;
  endtask
  task automatic acc(input logic [2:0] kind, input logic [7:0] off, input logic [2:0] pg);
    core.access(kind, off, 1'b0);
    #1;
    chk("sram_access", {sram_req_o, sram_addr_o}, {1'b1, pg, off});
    chk("sram_we", {11'h000, sram_we_o}, {11'h000, kind == 3'h5});
  endtask
  function automatic logic [2:0] page_of(input logic [1:0] mode, input logic [2:0] kind);
    case (kind)
      3'h1: page_of = (mode == 2'h0) ? 3'h0 : (mode == 2'h2) ? IDX : STK;
      3'h2: page_of = STK;
      3'h4: page_of = MVR;
      3'h5: page_of = MVW;
      default: page_of = mode[1] ? CUR : 3'h0;
    endcase
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    final_report();
  end
  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, reg_bank_i, reg_addr_i, reg_wdata_i} = '0;
    {flag_wr_i, irq_entry_i, irq_return_i, sp_wr_i, sp_push_i, sp_pop_i} = '0;
    {flag_wdata_i, flag_popped_i, sp_wdata_i} = '0;
    clk_en_i = 1'b1;
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) reg_chk(PG_ADDR[i], 12'h100);
    $display("test reset_values done");
    for (int i = 0; i < 5; i++) reg_wr(1'b0, PG_ADDR[i], {5'h00, PG_VAL[i]});
    reg_wr(1'b1, `SPS_OFF_CUR_PAGE, 8'h07);
    for (int i = 0; i < 5; i++) reg_chk(PG_ADDR[i], {4'h1, 5'h00, PG_VAL[i]});
    reg_chk(8'hD2, 12'h000);
    for (int i = 0; i < 4; i++) begin
      reg_wr(1'(i), 8'(`SPS_OFF_SCRATCH_BASE + i), 8'(8'hA0 + i));
      reg_chk(8'(`SPS_OFF_SCRATCH_BASE + i), {4'h1, 8'(8'hA0 + i)});
    end
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      strobe(FW, {2'(m), 6'h00});
      for (int k = 0; k < 6; k++) begin
        acc(3'(k), 8'(8'hF0 + k), page_of(2'(m), 3'(k)));
        acc(3'(k), 8'h00, page_of(2'(m), 3'(k)));
      end
    end
    core.access(3'h1, 8'hD0, 1'b1);
    #1;
    chk("reg_space", {reg_req_o, sram_req_o, 2'h0, reg_addr_o}, 12'h8D0);
    $display("test paging done");
    strobe(IE, 8'h00);
    chk("flag_pushed", {4'h0, flag_pushed_o}, 12'h0C0);
    acc(3'h1, 8'h10, 3'h0);
    strobe(FW, 8'h40);
    acc(3'h1, 8'h11, STK);
    strobe(IR, 8'hC0);
    chk("flag_restored", {4'h0, flag_o}, 12'h0C0);
    acc(3'h0, 8'h12, CUR);
    $display("test interrupt done");
    strobe(SW, 8'hFF);
    strobe(PU, 8'h00);
    chk("sp_up", {4'h0, stack_pointer_o}, 12'h000);
    strobe(PO, 8'h00);
    chk("sp_down", {4'h0, stack_pointer_o}, 12'h0FF);
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    strobe(PU, 8'h00);
    chk("sp_frozen", {4'h0, stack_pointer_o}, 12'h0FF);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    {rst_n_i, clk_en_i} <= 2'b11;
    #1;
    chk("reset_flag", {4'h0, flag_o}, 12'h000);
    chk("reset_sp", {4'h0, stack_pointer_o}, 12'h000);
    for (int i = 0; i < 5; i++) reg_chk(PG_ADDR[i], 12'h100);
    reg_chk(`SPS_OFF_SCRATCH_BASE, 12'h100);
    $display("test freeze_reset done");
    reg_wr(1'b0, `SPS_OFF_STK_PAGE, 8'h05);
    acc(3'h2, 8'hFF, 3'h5);
    reg_wr(1'b0, `SPS_OFF_STK_PAGE, {5'h00, STK});
    $display("test stack done");
    final_report();
  end
endmodule
`default_nettype wire
